// ### rtl/uemr_core.sv
// Purpose: Picks the handshake for each token from the endpoint mode and
//          updates mode, events, toggle, valid, count and interrupts.
// Assumes: Receiver hands over one token summary per packet; bytes of a
//          data packet arrive before its summary.
// Notes: Buffer may hold junk after a rejected packet.
`timescale 1ns/10ps
module uemr_core #(
    parameter int P_MAX_DATA = 8,
    parameter int P_BUF_DEPTH = 10
) (
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Received packet path
    input wire logic i_rx_byte_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_tok_valid,
    input wire uemr_pkg::uemr_token_t i_tok,
    // Host handshake after a transmit
    input wire logic i_hs_valid,
    input wire logic i_hs_ack,
    // Answer to the transmitter
    output uemr_pkg::uemr_resp_t o_resp,
    output logic o_resp_valid,
    // Register port
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Interrupt
    output logic o_irq
);

    // Endpoint state
    logic [3:0] mode_r, mode_nxt;
    logic [3:0] ev_r, ev_nxt;
    logic tog_r, tog_nxt;
    logic val_r, val_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic stall_r, stall_nxt;
    logic nakie_r, nakie_nxt;
    uemr_pkg::uemr_state_t st_r, st_nxt;
    uemr_pkg::uemr_resp_t resp_r, resp_nxt;
    logic resp_v_r, resp_v_nxt;
    logic [uemr_pkg::UEMR_IRQ_W-1:0] ev_irq;
    logic [uemr_pkg::UEMR_IRQ_W-1:0] mask_r, mask_nxt;
    logic [uemr_pkg::UEMR_IRQ_W-1:0] int_st;
    logic [uemr_pkg::UEMR_IRQ_W-1:0] int_clr;
    logic irq_r, irq_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    // Receive buffer
    logic [7:0] buf_mem [P_BUF_DEPTH];
    logic [3:0] wptr_r, wptr_nxt;

    // Decoded token
    logic is_setup, is_out, is_in, ok_ctrl, ok_data;
    logic wr_mode, wr_cnt, wr_ctrl, wr_mask, wr_ist;

    always_comb begin
        is_setup = i_tok_valid && (i_tok.kind == uemr_pkg::UEMR_TOK_SETUP);
        is_out = i_tok_valid && (i_tok.kind == uemr_pkg::UEMR_TOK_OUT);
        is_in = i_tok_valid && (i_tok.kind == uemr_pkg::UEMR_TOK_IN);
        // Length or data faults give no handshake at all
        ok_ctrl = i_tok.data_ok
            && (i_tok.count <= uemr_pkg::UEMR_CTRL_MAX);
        ok_data = i_tok.data_ok
            && (i_tok.count <= UEMR_CNT_W_MAX(P_MAX_DATA));
        wr_mode = i_wr && (i_addr == uemr_pkg::UEMR_A_MODE);
        wr_cnt = i_wr && (i_addr == uemr_pkg::UEMR_A_COUNT);
        wr_ctrl = i_wr && (i_addr == uemr_pkg::UEMR_A_CTRL);
        wr_ist = i_wr && (i_addr == uemr_pkg::UEMR_A_INT_ST);
        wr_mask = i_wr && (i_addr == uemr_pkg::UEMR_A_INT_MASK);
    end

    function automatic logic [5:0] UEMR_CNT_W_MAX(input int m);
        UEMR_CNT_W_MAX = m[5:0];
    endfunction : UEMR_CNT_W_MAX

    // Handshake decision and register updates
    always_comb begin
        mode_nxt = mode_r;
        ev_nxt = ev_r;
        tog_nxt = tog_r;
        val_nxt = val_r;
        cnt_nxt = cnt_r;
        stall_nxt = stall_r;
        nakie_nxt = nakie_r;
        mask_nxt = mask_r;
        st_nxt = st_r;
        resp_nxt = resp_r;
        resp_v_nxt = 1'b0;
        ev_irq = '0;
        // Firmware writes first, so hardware updates below win
        if (wr_mode) begin
            mode_nxt = i_wdata[3:0];
            ev_nxt = ev_r & ~i_wdata[7:4];
        end
        if (wr_cnt) begin
            tog_nxt = i_wdata[uemr_pkg::UEMR_CNT_TOG];
            val_nxt = i_wdata[uemr_pkg::UEMR_CNT_VAL];
            cnt_nxt = i_wdata[3:0];
        end
        if (wr_ctrl) begin
            stall_nxt = i_wdata[uemr_pkg::UEMR_CTRL_STALL];
            nakie_nxt = i_wdata[uemr_pkg::UEMR_CTRL_NAKIE];
        end
        if (wr_mask) begin
            mask_nxt = i_wdata[uemr_pkg::UEMR_IRQ_W-1:0];
        end
        // Host answer to a transmit; a new token drops the wait
        if (st_r != uemr_pkg::UEMR_S_IDLE) begin
            if (i_tok_valid) begin
                st_nxt = uemr_pkg::UEMR_S_IDLE;
            end else if (i_hs_valid) begin
                st_nxt = uemr_pkg::UEMR_S_IDLE;
                if (i_hs_ack && st_r == uemr_pkg::UEMR_S_WAIT_ZLP) begin
                    ev_nxt[uemr_pkg::UEMR_EV_I - 4] = 1'b1;
                    ev_nxt[uemr_pkg::UEMR_EV_A - 4] = 1'b1;
                    mode_nxt = uemr_pkg::UEMR_M_STALL_BOTH;
                    ev_irq[uemr_pkg::UEMR_IRQ_EP] = 1'b1;
                end else if (i_hs_ack) begin
                    ev_nxt[uemr_pkg::UEMR_EV_A - 4] = 1'b1;
                    mode_nxt = uemr_pkg::UEMR_M_NAK_IN;
                    ev_irq[uemr_pkg::UEMR_IRQ_EP] = 1'b1;
                end
            end
        end
        // Token decision by mode; unlisted cases are ignored
        case (mode_r)
            uemr_pkg::UEMR_M_STATUS_OUT,
            uemr_pkg::UEMR_M_ACKOUT_STIN,
            uemr_pkg::UEMR_M_STATUS_IN: begin
                if (is_setup && ok_ctrl) begin
                    resp_nxt = '{uemr_pkg::UEMR_R_ACK, 4'h0};
                    resp_v_nxt = 1'b1;
                    ev_nxt[uemr_pkg::UEMR_EV_S - 4] = 1'b1;
                    ev_nxt[uemr_pkg::UEMR_EV_A - 4] = 1'b1;
                    mode_nxt = uemr_pkg::UEMR_M_NAK_BOTH;
                    tog_nxt = i_tok.toggle;
                    val_nxt = 1'b1;
                    cnt_nxt = i_tok.count[3:0];
                    ev_irq[uemr_pkg::UEMR_IRQ_EP] = 1'b1;
                end else if (is_in
                    && mode_r != uemr_pkg::UEMR_M_STATUS_OUT) begin
                    // Zero-length data; success waits for the host
                    resp_nxt = '{uemr_pkg::UEMR_R_TX,
                        uemr_pkg::UEMR_ZLP_LEN};
                    resp_v_nxt = 1'b1;
                    st_nxt = uemr_pkg::UEMR_S_WAIT_ZLP;
                end else if (is_out && ok_ctrl
                    && mode_r == uemr_pkg::UEMR_M_ACKOUT_STIN) begin
                    resp_nxt = '{uemr_pkg::UEMR_R_ACK, 4'h0};
                    resp_v_nxt = 1'b1;
                    ev_nxt[uemr_pkg::UEMR_EV_O - 4] = 1'b1;
                    ev_nxt[uemr_pkg::UEMR_EV_A - 4] = 1'b1;
                    mode_nxt = uemr_pkg::UEMR_M_NAK_BOTH;
                    tog_nxt = i_tok.toggle;
                    val_nxt = 1'b1;
                    cnt_nxt = i_tok.count[3:0];
                    ev_irq[uemr_pkg::UEMR_IRQ_EP] = 1'b1;
                end else if (is_out && ok_ctrl
                    && mode_r == uemr_pkg::UEMR_M_STATUS_OUT
                    && i_tok.count == uemr_pkg::UEMR_STATUS_LEN
                    && i_tok.toggle) begin
                    resp_nxt = '{uemr_pkg::UEMR_R_ACK, 4'h0};
                    resp_v_nxt = 1'b1;
                    ev_nxt[uemr_pkg::UEMR_EV_O - 4] = 1'b1;
                    ev_nxt[uemr_pkg::UEMR_EV_A - 4] = 1'b1;
                    tog_nxt = 1'b1;
                    val_nxt = 1'b1;
                    cnt_nxt = uemr_pkg::UEMR_STATUS_LEN[3:0];
                    ev_irq[uemr_pkg::UEMR_IRQ_EP] = 1'b1;
                end else if (is_out && ok_ctrl) begin
                    // Bad status stage or OUT during status-in
                    resp_nxt = '{uemr_pkg::UEMR_R_STALL, 4'h0};
                    resp_v_nxt = 1'b1;
                    mode_nxt = uemr_pkg::UEMR_M_STALL_BOTH;
                    ev_irq[uemr_pkg::UEMR_IRQ_EP] = 1'b1;
                end
            end
            uemr_pkg::UEMR_M_ACK_OUT: begin
                if (is_out && ok_data && stall_r) begin
                    resp_nxt = '{uemr_pkg::UEMR_R_STALL, 4'h0};
                    resp_v_nxt = 1'b1;
                end else if (is_out && ok_data) begin
                    resp_nxt = '{uemr_pkg::UEMR_R_ACK, 4'h0};
                    resp_v_nxt = 1'b1;
                    ev_nxt[uemr_pkg::UEMR_EV_A - 4] = 1'b1;
                    mode_nxt = uemr_pkg::UEMR_M_NAK_OUT;
                    tog_nxt = i_tok.toggle;
                    val_nxt = 1'b1;
                    cnt_nxt = i_tok.count[3:0];
                    ev_irq[uemr_pkg::UEMR_IRQ_EP] = 1'b1;
                end
            end
            uemr_pkg::UEMR_M_NAK_OUT: begin
                if (is_out && ok_data) begin
                    resp_nxt = '{uemr_pkg::UEMR_R_NAK, 4'h0};
                    resp_v_nxt = 1'b1;
                    ev_irq[uemr_pkg::UEMR_IRQ_NAK] = nakie_r;
                end
            end
            uemr_pkg::UEMR_M_ACK_IN: begin
                if (is_in && stall_r) begin
                    resp_nxt = '{uemr_pkg::UEMR_R_STALL, 4'h0};
                    resp_v_nxt = 1'b1;
                end else if (is_in) begin
                    resp_nxt = '{uemr_pkg::UEMR_R_TX, cnt_r};
                    resp_v_nxt = 1'b1;
                    st_nxt = uemr_pkg::UEMR_S_WAIT_TX;
                end
            end
            uemr_pkg::UEMR_M_NAK_IN: begin
                if (is_in) begin
                    resp_nxt = '{uemr_pkg::UEMR_R_NAK, 4'h0};
                    resp_v_nxt = 1'b1;
                    ev_irq[uemr_pkg::UEMR_IRQ_NAK] = nakie_r;
                end
            end
            default: begin
                resp_nxt = resp_r;
            end
        endcase
        // Interrupt level from the status as it will stand
        irq_nxt = |(((int_st & ~int_clr) | ev_irq) & mask_nxt);
    end

    // Endpoint state registers
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            mode_r <= 4'h0;
            ev_r <= 4'h0;
            tog_r <= 1'b0;
            val_r <= 1'b0;
            cnt_r <= 4'h0;
            stall_r <= 1'b0;
            nakie_r <= 1'b0;
            mask_r <= '0;
            st_r <= uemr_pkg::UEMR_S_IDLE;
            resp_r <= '{uemr_pkg::UEMR_R_NONE, 4'h0};
            resp_v_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (i_ce) begin
            mode_r <= mode_nxt;
            ev_r <= ev_nxt;
            tog_r <= tog_nxt;
            val_r <= val_nxt;
            cnt_r <= cnt_nxt;
            stall_r <= stall_nxt;
            nakie_r <= nakie_nxt;
            mask_r <= mask_nxt;
            st_r <= st_nxt;
            resp_r <= resp_nxt;
            resp_v_r <= resp_v_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Sticky interrupt status, write one to clear
    assign int_clr = wr_ist ? i_wdata[uemr_pkg::UEMR_IRQ_W-1:0] : '0;

    uemr_sticky #(
        .W(uemr_pkg::UEMR_IRQ_W)
    ) u_int_st (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_set(ev_irq),
        .i_clr(int_clr),
        .o_q(int_st)
    );

    // Buffer fill; a rejected packet simply leaves junk behind
    always_comb begin
        wptr_nxt = wptr_r;
        if (i_tok_valid) begin
            wptr_nxt = 4'h0;
        end else if (i_rx_byte_valid && wptr_r < P_BUF_DEPTH[3:0]) begin
            wptr_nxt = wptr_r + 4'h1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            wptr_r <= 4'h0;
        end else if (i_ce) begin
            wptr_r <= wptr_nxt;
            if (i_rx_byte_valid && !i_tok_valid
                && wptr_r < P_BUF_DEPTH[3:0]) begin
                buf_mem[wptr_r] <= i_rx_byte;
            end
        end
    end

    // Read mux, answer one cycle after the strobe
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_rd) begin
            if (i_addr[uemr_pkg::UEMR_BUF_BIT]) begin
                if (i_addr[3:0] < P_BUF_DEPTH[3:0]) begin
                    rdata_nxt = buf_mem[i_addr[3:0]];
                end
            end else begin
                case (i_addr)
                    uemr_pkg::UEMR_A_MODE: rdata_nxt = {ev_r, mode_r};
                    uemr_pkg::UEMR_A_COUNT: rdata_nxt = {tog_r, val_r,
                        2'b00, cnt_r};
                    uemr_pkg::UEMR_A_CTRL: rdata_nxt = {6'h00, nakie_r,
                        stall_r};
                    uemr_pkg::UEMR_A_INT_ST: rdata_nxt = {6'h00, int_st};
                    uemr_pkg::UEMR_A_INT_MASK: rdata_nxt = {6'h00, mask_r};
                    default: rdata_nxt = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            rdata_r <= 8'h00;
        end else if (i_ce) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs straight from flops
    assign o_resp = resp_r;
    assign o_resp_valid = resp_v_r;
    assign o_rdata = rdata_r;
    assign o_irq = irq_r;

endmodule : uemr_core

// ### rtl/uemr_pkg.sv
// Purpose: Shared constants and types for the endpoint mode responder.
// Assumes: One endpoint; token results arrive as one-cycle summaries.
// Notes: All offsets are byte addresses on the plain register port.

package uemr_pkg;

    // Endpoint modes
    localparam logic [3:0] UEMR_M_STALL_BOTH = 4'h3;
    localparam logic [3:0] UEMR_M_NAK_BOTH = 4'h1;
    localparam logic [3:0] UEMR_M_STATUS_OUT = 4'h2;
    localparam logic [3:0] UEMR_M_ACKOUT_STIN = 4'hB;
    localparam logic [3:0] UEMR_M_STATUS_IN = 4'h6;
    localparam logic [3:0] UEMR_M_ACK_OUT = 4'h9;
    localparam logic [3:0] UEMR_M_NAK_OUT = 4'h8;
    localparam logic [3:0] UEMR_M_ACK_IN = 4'hD;
    localparam logic [3:0] UEMR_M_NAK_IN = 4'hC;

    // Packet length limits
    localparam int UEMR_CNT_W = 6;
    localparam logic [5:0] UEMR_CTRL_MAX = 6'h0A;
    localparam logic [5:0] UEMR_STATUS_LEN = 6'h02;
    localparam logic [3:0] UEMR_ZLP_LEN = 4'h0;

    // Register byte addresses
    localparam logic [4:0] UEMR_A_MODE = 5'h00;
    localparam logic [4:0] UEMR_A_COUNT = 5'h01;
    localparam logic [4:0] UEMR_A_CTRL = 5'h02;
    localparam logic [4:0] UEMR_A_INT_ST = 5'h03;
    localparam logic [4:0] UEMR_A_INT_MASK = 5'h04;
    localparam int UEMR_BUF_BIT = 4;

    // Field positions
    localparam int UEMR_EV_S = 7;
    localparam int UEMR_EV_I = 6;
    localparam int UEMR_EV_O = 5;
    localparam int UEMR_EV_A = 4;
    localparam int UEMR_CNT_TOG = 7;
    localparam int UEMR_CNT_VAL = 6;
    localparam int UEMR_CTRL_STALL = 0;
    localparam int UEMR_CTRL_NAKIE = 1;
    localparam int UEMR_IRQ_EP = 0;
    localparam int UEMR_IRQ_NAK = 1;
    localparam int UEMR_IRQ_W = 2;

    // Token kinds
    typedef enum logic [1:0] {
        UEMR_TOK_SETUP = 2'h0,
        UEMR_TOK_OUT = 2'h1,
        UEMR_TOK_IN = 2'h2
    } uemr_tok_t;

    // Handshake choices
    typedef enum logic [2:0] {
        UEMR_R_NONE = 3'h0,
        UEMR_R_ACK = 3'h1,
        UEMR_R_NAK = 3'h2,
        UEMR_R_STALL = 3'h3,
        UEMR_R_TX = 3'h4
    } uemr_resp_kind_t;

    // Token summary from the receiver
    typedef struct packed {
        uemr_tok_t kind;
        logic [5:0] count;
        logic data_ok;
        logic toggle;
    } uemr_token_t;

    // Answer to the transmitter
    typedef struct packed {
        uemr_resp_kind_t kind;
        logic [3:0] len;
    } uemr_resp_t;

    // Handshake wait state
    typedef enum logic [1:0] {
        UEMR_S_IDLE = 2'b00,
        UEMR_S_WAIT_ZLP = 2'b01,
        UEMR_S_WAIT_TX = 2'b10
    } uemr_state_t;

endpackage : uemr_pkg

// ### rtl/uemr_sticky.sv
// Purpose: Sticky event bits, cleared by writing ones.
// Assumes: Set and clear arrive in the same clock domain.
// Notes: A set in the clear cycle wins, so no event is lost.
`timescale 1ns/10ps
module uemr_sticky #(
    parameter int W = 2
) (
    // Clock and control
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Events and clears
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_q
);

    logic [W-1:0] q_nxt;

    // Set dominates clear
    always_comb begin
        q_nxt = (o_q & ~i_clr) | i_set;
    end

    // Register only
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_q <= '0;
        end else if (i_ce) begin
            o_q <= q_nxt;
        end
    end

endmodule : uemr_sticky

// ### tb/uemr_assertions.sv
// Purpose: Port-level checks of the endpoint responder.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Sees only the top ports; bound at the foot.
`timescale 1ns/10ps
module uemr_assertions #(
    parameter int P_MAX_DATA = 8,
    parameter int P_BUF_DEPTH = 10
) (
    // Clock and control
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Packet side
    input wire logic i_tok_valid,
    input wire uemr_pkg::uemr_token_t i_tok,
    input wire logic i_hs_valid,
    input wire uemr_pkg::uemr_resp_t o_resp,
    input wire logic o_resp_valid,
    // Register side
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_irq
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);
    // Token taken this edge, and whether it carries data
    wire tok_w = i_tok_valid && i_ce;
    wire dat_w = tok_w && (i_tok.kind != uemr_pkg::UEMR_TOK_IN);

    a_resp_has_token: assert property (o_resp_valid |-> $past(tok_w))
        else $error("answer without a token");
    a_bad_data_quiet: assert property (dat_w && !i_tok.data_ok
        |=> !o_resp_valid) else $error("bad packet answered");
    a_long_pkt_quiet: assert property (dat_w
        && i_tok.count > uemr_pkg::UEMR_CTRL_MAX |=> !o_resp_valid)
        else $error("long packet answered");
    a_in_no_ack: assert property (tok_w && !dat_w |=> !o_resp_valid
        || o_resp.kind != uemr_pkg::UEMR_R_ACK) else $error("IN got ACK");
    a_out_no_tx: assert property (dat_w |=> !o_resp_valid
        || o_resp.kind != uemr_pkg::UEMR_R_TX) else $error("OUT got data");
    a_ack_in_range: assert property (o_resp_valid
        && o_resp.kind == uemr_pkg::UEMR_R_ACK |-> $past(i_tok.data_ok)
        && $past(i_tok.count) <= uemr_pkg::UEMR_CTRL_MAX)
        else $error("ACK for bad or long packet");
    a_irq_has_cause: assert property ($rose(o_irq)
        |-> $past(tok_w || i_hs_valid || i_wr) || $past(i_hs_valid || i_wr, 2))
        else $error("interrupt without cause");
    a_rdata_idle: assert property (!$past(i_rd && i_ce) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_resp_holds: assert property (!o_resp_valid |-> $stable(o_resp))
        else $error("answer changed without pulse");
    // Main traffic kinds
    c_ack: cover property (o_resp_valid && o_resp.kind == uemr_pkg::UEMR_R_ACK);
    c_tx: cover property (o_resp_valid && o_resp.kind == uemr_pkg::UEMR_R_TX);
    c_nak: cover property (o_resp_valid && o_resp.kind == uemr_pkg::UEMR_R_NAK);
    c_irq: cover property ($rose(o_irq));
endmodule : uemr_assertions

bind uemr_core uemr_assertions #(
    .P_MAX_DATA(P_MAX_DATA),
    .P_BUF_DEPTH(P_BUF_DEPTH)
) uemr_assertions_inst (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_tok_valid(i_tok_valid), .i_tok(i_tok), .i_hs_valid(i_hs_valid),
    .o_resp(o_resp), .o_resp_valid(o_resp_valid), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq)
);

// ### tb/uemr_core_bench.sv
// Purpose: Random traffic against a reference model of the responder.
// Assumes: Clock enable held high; firmware rewrites mode each packet.
// Notes: Model kept in plain integers.
`timescale 1ns/10ps
module uemr_core_bench;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic [4:0] i_addr = 5'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic o_irq, rxv, tv, hv, ha, o_resp_valid, rv;
    logic [7:0] rxb, v;
    logic [2:0] rk;
    logic [3:0] rl;
    uemr_pkg::uemr_token_t tok;
    uemr_pkg::uemr_resp_t o_resp;
    int num_errors = 0, checks_done = 0, cycles = 0;
    int m_mode, m_ev, m_tog, m_val, m_cnt, m_ctrl, m_ist, m_mask, m_wait;
    int md, k, c, ok, tg, d, ek, el;
    int modes [8] = '{0, 2, 11, 6, 9, 8, 13, 12};

    always #50 i_mclk = ~i_mclk;
    uemr_core uemr_core_inst (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .i_ce(1'b1), .i_rx_byte_valid(rxv), .i_rx_byte(rxb),
        .i_tok_valid(tv), .i_tok(tok), .i_hs_valid(hv), .i_hs_ack(ha),
        .o_resp(o_resp), .o_resp_valid(o_resp_valid), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_irq(o_irq));
    uemr_host_model uemr_host_model_inst (.i_mclk(i_mclk),
        .o_rx_byte_valid(rxv), .o_rx_byte(rxb), .o_tok_valid(tv),
        .o_tok(tok), .o_hs_valid(hv), .o_hs_ack(ha), .i_resp(o_resp),
        .i_resp_valid(o_resp_valid));

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [7:0] s,
                       input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] dt);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= dt;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        q = o_rdata;
    endtask : rd
    // Model: accepted data packet
    task automatic acc(input int ev, input int nm);
        m_ev |= ev;
        if (nm >= 0) m_mode = nm;
        m_tog = tg;
        m_val = 1;
        m_cnt = c & 15;
        m_ist |= 1;
    endtask : acc
    // Model: choose handshake and update state
    task automatic model_tok();
        int good;
        good = ok && c <= ((m_mode == 8 || m_mode == 9) ? 8 : 10);
        ek = 0;
        el = 0;
        m_wait = 0;
        if (m_mode inside {2, 6, 11}) begin
            if (k == 0 && good) begin ek = 1; acc(9, 1); end
            // IN during status-out is left unanswered
            else if (k == 2 && m_mode != 2) begin ek = 4; m_wait = 1; end
            else if (k == 1 && good && m_mode == 11) begin ek = 1; acc(3, 1); end
            else if (k == 1 && good && m_mode == 2 && c == 2 && tg) begin
                ek = 1;
                acc(3, -1);
            end else if (k == 1 && good) begin ek = 3; m_mode = 3; m_ist |= 1; end
        end else if ((m_mode == 9 && k == 1 && good)
                     || (m_mode == 13 && k == 2)) begin
            if (m_ctrl & 1) ek = 3;
            else if (m_mode == 9) begin ek = 1; acc(1, 8); end
            else begin ek = 4; el = m_cnt; m_wait = 2; end
        end else if ((m_mode == 8 && k == 1 && good)
                     || (m_mode == 12 && k == 2)) begin
            ek = 2;
            if (m_ctrl & 2) m_ist |= 2;
        end
    endtask : model_tok

    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        void'($urandom(32'h77da_4014));
        repeat (16) @(posedge i_mclk);
        i_resetn <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            rd(5'(a), v);
            chk("reset value", v, 8'h00);
        end
        wr(5'h08, 8'hFF);
        rd(5'h08, v);
        chk("unmapped", v, 8'h00);
        $display("test reset and unmapped done");
        for (int n = 0; n < 400; n++) begin
            md = modes[$urandom_range(7)];
            k = (md >= 8) ? $urandom_range(2, 1) : $urandom_range(2);
            c = $urandom_range(12);
            ok = ($urandom_range(3) != 0);
            tg = $urandom_range(1);
            d = $urandom;
            wr(5'h00, {4'hF, 4'(md)});
            wr(5'h01, 8'(d) & 8'hCF);
            wr(5'h02, 8'(d >> 8) & 8'h03);
            wr(5'h04, 8'(d >> 16) & 8'h03);
            wr(5'h03, 8'h03);
            m_ev = 0;
            m_mode = md;
            m_tog = d[7];
            m_val = d[6];
            m_cnt = d & 15;
            m_ctrl = (d >> 8) & 3;
            m_mask = (d >> 16) & 3;
            m_ist = 0;
            uemr_host_model_inst.send(k, c, ok, tg, rv, rk, rl);
            model_tok();
            chk("answer pulse", {7'h0, rv}, 8'(ek != 0));
            if (ek != 0) chk("answer kind", {5'h0, rk}, 8'(ek));
            if (ek == 4) begin
                chk("tx length", {4'h0, rl}, 8'(el));
                d = $urandom_range(1);
                uemr_host_model_inst.hs(d[0]);
                if (d && m_wait == 1) begin m_ev |= 5; m_mode = 3; m_ist |= 1; end
                if (d && m_wait == 2) begin m_ev |= 1; m_mode = 12; m_ist |= 1; end
            end
            rd(5'h00, v);
            chk("mode", v, 8'(m_ev * 16 + m_mode));
            rd(5'h01, v);
            chk("count", v, 8'(m_tog * 128 + m_val * 64 + m_cnt));
            rd(5'h03, v);
            chk("int status", v, 8'(m_ist));
            chk("irq", {7'h0, o_irq}, 8'((m_ist & m_mask) != 0));
            for (int i = 0; i < ((ek == 1 && k != 2) ? c : 0); i++) begin
                rd(5'(16 + i), v);
                chk("buffer", v, uemr_host_model_inst.sent[i]);
            end
        end
        $display("test random traffic done");
        conclude();
    end
endmodule : uemr_core_bench

// ### tb/uemr_host_model.sv
// Purpose: Host side: sends packets and handshakes to the responder.
// Assumes: Summary pulse follows the data bytes.
// Notes: Released lines show inverted junk so stale values never match.
`timescale 1ns/10ps
module uemr_host_model (
    // Clock
    input wire logic i_mclk,
    // Toward the responder
    output logic o_rx_byte_valid,
    output logic [7:0] o_rx_byte,
    output logic o_tok_valid,
    output uemr_pkg::uemr_token_t o_tok,
    output logic o_hs_valid,
    output logic o_hs_ack,
    // Answer from the responder
    input wire uemr_pkg::uemr_resp_t i_resp,
    input wire logic i_resp_valid
);
    logic [7:0] sent [16];
    // Idle bus at time zero
    initial begin
        o_rx_byte_valid = 1'b0;
        o_rx_byte = 8'h00;
        o_tok_valid = 1'b0;
        o_tok = '0;
        o_hs_valid = 1'b0;
        o_hs_ack = 1'b0;
    end
    // Data bytes, then summary; answer sampled one cycle on
    task automatic send(input int k, input int c, input int ok, input int tg,
                        output logic rv, output logic [2:0] rk,
                        output logic [3:0] rl);
        for (int i = 0; i < ((k == 2) ? 0 : c); i++) begin
            @(posedge i_mclk);
            sent[i] = 8'($urandom);
            o_rx_byte_valid <= 1'b1;
            o_rx_byte <= sent[i];
        end
        @(posedge i_mclk);
        o_rx_byte_valid <= 1'b0;
        o_rx_byte <= ~o_rx_byte;
        o_tok_valid <= 1'b1;
        o_tok <= '{uemr_pkg::uemr_tok_t'(k), 6'(c), 1'(ok), 1'(tg)};
        @(posedge i_mclk);
        o_tok_valid <= 1'b0;
        o_tok <= uemr_pkg::uemr_token_t'(~o_tok);
        #1;
        rv = i_resp_valid;
        rk = i_resp.kind;
        rl = i_resp.len;
    endtask : send
    // Host reaction after a data transmission
    task automatic hs(input logic a);
        @(posedge i_mclk);
        o_hs_valid <= 1'b1;
        o_hs_ack <= a;
        @(posedge i_mclk);
        o_hs_valid <= 1'b0;
        o_hs_ack <= ~a;
    endtask : hs
endmodule : uemr_host_model
